/* File: ssp_sync_serial_port.sv */
// Synchronous serial port: master or slave shift engine with baud generator
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
// How it works
// - Enabled master clock idles, data holds level
// - Data line keeps last bit after frame
// - Master loads buffer, first bit on tick
// - Master samples input on opposite clock edge
// - Frame end copies shift register, sets rx flag
// - Slave drives first bit immediately on load
// - Every transfer shifts out and in together
// - Disabled port holds alternate outputs high
// - Unused alternate output stays high
// - Receiver shifts in the other line: master in for master, master out for slave
// - Reloaded buffer starts next frame without gap
// - Role handover switches mode; pin directions stay with software
// - Mode change reroutes alternate inputs and outputs
// - Baud counter: 16-bit down, half clock, gated
// - Baud read gives counter when enabled, else reload
// - Bit rate is clock over 2(reload+1)
// - Width 2..16, right aligned data buffers
// - Idle level and phase select shifting edge
// - Transfer start sets busy and tx flag
// - Bit order selects LSB or MSB first
module ssp_sync_serial_port
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe_n,
    input wire logic master_out_line_i,
    output logic master_out_line_o,
    output logic master_out_line_oe_n,
    input wire logic master_in_line_i,
    output logic master_in_line_o,
    output logic master_in_line_oe_n
);

    // Registers seen by software
    logic [15:0] ctrl_q, ctrl_d;        // Mode and enable
    logic [15:0] baud_q, baud_d;        // baud_reload
    logic [5:0] port_q, port_d;         // Port latches and directions
    logic [15:0] txb_q, txb_d;          // tx_buffer
    logic txf_q, txf_d;                 // tx_buffer holds data
    logic [15:0] rxb_q, rxb_d;          // rx_buffer
    logic busy_q, busy_d;               // busy_flag
    logic tir_q, tir_d;                 // tx_irq_flag
    logic rir_q, rir_d;                 // rx_irq_flag
    // Shift engine
    logic [15:0] sr_q, sr_d;            // Shift register
    logic out_q, out_d;                 // Data bit on the line
    logic clk_q, clk_d;                 // Generated shift clock
    ssp_state_e st_q, st_d;             // Engine state
    logic [4:0] k_q, k_d;               // Clock edge index in frame
    // Bus slave
    logic ack_q, ack_d;
    logic [15:0] dat_q, dat_d;
    // Baud generator
    logic half_q, half_d;               // Half clock enable
    logic [15:0] cnt_q, cnt_d;          // Down counter
    logic [15:0] hcnt_q, hcnt_d;        // Trailing edge timer
    logic arm_q, arm_d;                 // Trailing edge pending
    // Synchronisers
    logic sclk_s1, sclk_s2, sclk_s3;
    logic mo_s1, mo_s2, mi_s1, mi_s2;
    // Decoded controls
    logic en, ms, ph, po, msb;
    logic [3:0] wm1;
    logic [4:0] last;
    logic rx_in, req, wr_go;
    logic [15:0] port_m;                // Port register after a lane merge
    logic lead_tick, trail_tick;
    logic alt_sclk, alt_mout, alt_min;
    // Engine events, also watched by the checks
    logic load_ev, fend, ld_slave, edge_ev, samp;
    logic [15:0] sh;
    logic [15:0] stat;

    // Bit presented first for the chosen order
    function automatic logic first_bit(input logic [15:0] v, input logic [3:0] w,
                                       input logic m);
        return m ? v[w] : v[0];
    endfunction

    // One shift step, new bit enters at the far end of the word
    function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
                                             input logic [3:0] w, input logic m);
        logic [15:0] r;
        r = m ? {v[14:0], b} : {1'b0, v[15:1]};
        if (!m) begin
            r[w] = b;
        end
        return r;
    endfunction

    // Byte lane merge of a bus write
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Control decode
    assign en = ctrl_q[CT_EN];
    assign ms = ctrl_q[CT_MS];
    assign ph = ctrl_q[CT_PH];
    assign po = ctrl_q[CT_PO];
    assign msb = ctrl_q[CT_MSB];
    assign wm1 = (ctrl_q[CT_WID +: 4] < WID_MIN) ? WID_MIN : ctrl_q[CT_WID +: 4];
    assign last = {wm1, 1'b1};
    // Input routed by role: master hears master in, slave hears master out
    assign rx_in = ms ? mi_s2 : mo_s2;
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    // Writes land at the edge where the master samples ack
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign port_m = merge(16'(port_q), wb_dat_i, wb_sel_i);
    assign wb_ack_o = ack_q;
    assign wb_dat_o = {ZERO16, dat_q};

    // Alternate outputs: high when disabled or unused
    assign alt_sclk = (en && ms) ? clk_q : 1'b1;
    assign alt_mout = (en && ms) ? out_q : 1'b1;
    assign alt_min = (en && !ms) ? out_q : 1'b1;
    // Pin level is latch AND alternate output
    assign shift_clock_pin_o = port_q[PT_SCLK] & alt_sclk;
    assign master_out_line_o = port_q[PT_MOUT] & alt_mout;
    assign master_in_line_o = port_q[PT_MIN] & alt_min;
    // Directions stay under software control
    assign shift_clock_pin_oe_n = ~port_q[PT_DIR + PT_SCLK];
    assign master_out_line_oe_n = ~port_q[PT_DIR + PT_MOUT];
    assign master_in_line_oe_n = ~port_q[PT_DIR + PT_MIN];

    // Pin synchronisers, two flops each, a third on the clock for edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            mo_s1 <= 1'b0;
            mo_s2 <= 1'b0;
            mi_s1 <= 1'b0;
            mi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= shift_clock_pin_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            mo_s1 <= master_out_line_i;
            mo_s2 <= mo_s1;
            mi_s1 <= master_in_line_i;
            mi_s2 <= mi_s1;
        end
    end

    // Baud ticks: leading on underflow, trailing reload+1 cycles later
    assign lead_tick = en & half_q & (cnt_q == ZERO16);
    assign trail_tick = arm_q & (hcnt_q == ZERO16);

    // Baud generator next state
    always_comb begin
        half_d = en ? ~half_q : 1'b0;
        cnt_d = cnt_q;
        hcnt_d = hcnt_q;
        arm_d = arm_q;
        if (!en) begin
            // Stopped, preloaded with the reload value
            cnt_d = baud_q;
            arm_d = 1'b0;
        end else begin
            // Counts only on the half-rate enable
            if (half_q) begin
                cnt_d = (cnt_q == ZERO16) ? baud_q : 16'(cnt_q - 16'h0001);
            end
            // Second half of the bit period
            if (lead_tick) begin
                arm_d = 1'b1;
                hcnt_d = baud_q;
            end else if (arm_q) begin
                if (hcnt_q == ZERO16) begin
                    arm_d = 1'b0;
                end else begin
                    hcnt_d = 16'(hcnt_q - 16'h0001);
                end
            end
        end
    end

    // Baud generator registers
    always_ff @(posedge clk) begin
        if (reset) begin
            half_q <= 1'b0;
            cnt_q <= BAUD_RST;
            hcnt_q <= BAUD_RST;
            arm_q <= 1'b0;
        end else begin
            half_q <= half_d;
            cnt_q <= cnt_d;
            hcnt_q <= hcnt_d;
            arm_q <= arm_d;
        end
    end

    // Status word
    always_comb begin
        stat = ZERO16;
        stat[ST_BSY] = busy_q;
        stat[ST_TIR] = tir_q;
        stat[ST_RIR] = rir_q;
        stat[ST_TXF] = txf_q;
    end

    // Bus access and shift engine next state
    always_comb begin
        ctrl_d = ctrl_q;
        baud_d = baud_q;
        port_d = port_q;
        txb_d = txb_q;
        txf_d = txf_q;
        rxb_d = rxb_q;
        busy_d = busy_q;
        tir_d = tir_q;
        rir_d = rir_q;
        sr_d = sr_q;
        out_d = out_q;
        clk_d = clk_q;
        st_d = st_q;
        k_d = k_q;
        dat_d = dat_q;
        ack_d = req;
        load_ev = 1'b0;
        fend = 1'b0;
        ld_slave = 1'b0;
        edge_ev = 1'b0;
        samp = 1'b0;
        sh = sr_q;
        // Register reads, unmapped reads give zero
        if (req) begin
            case (wb_adr_i)
                ADR_CTRL: dat_d = ctrl_q;
                ADR_BAUD: dat_d = en ? cnt_q : baud_q;
                ADR_TXB: dat_d = txb_q;
                ADR_RXB: dat_d = rxb_q;
                ADR_STAT: dat_d = stat;
                ADR_PORT: dat_d = 16'(port_q);
                default: dat_d = ZERO16;
            endcase
        end
        // Register writes, flags clear first so hardware sets win
        if (wr_go) begin
            case (wb_adr_i)
                ADR_CTRL: ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
                ADR_BAUD: begin
                    if (!en) begin
                        baud_d = merge(baud_q, wb_dat_i, wb_sel_i);
                    end
                end
                ADR_PORT: port_d = port_m[5:0];
                ADR_STAT: begin
                    if (wb_sel_i[0] && wb_dat_i[ST_TIR]) begin
                        tir_d = 1'b0;
                    end
                    if (wb_sel_i[0] && wb_dat_i[ST_RIR]) begin
                        rir_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (!en) begin
            // Disabled: engine parked, clock held at idle level
            st_d = SSP_IDLE;
            k_d = K_ZERO;
            clk_d = po;
            busy_d = 1'b0;
        end else begin
            // Master edges come from ticks, slave edges from the pin
            if (ms) begin
                edge_ev = (st_q == SSP_RUN) && (lead_tick || trail_tick);
            end else begin
                edge_ev = (sclk_s2 != sclk_s3) && ((st_q == SSP_RUN) || (sclk_s2 != po));
            end
            if (edge_ev) begin
                // Even edges lead; phase picks which edge samples
                samp = (~k_q[0]) == ph;
                sh = samp ? shift_in(sr_q, rx_in, wm1, msb) : sr_q;
                sr_d = sh;
                if (ms) begin
                    clk_d = ~clk_q;
                end
                // Shifting edge: next bit out, not on first or last edge
                if (!samp && (k_q != K_ZERO) && (k_q != last)) begin
                    out_d = first_bit(sh, wm1, msb);
                end
                if (k_q == last) begin
                    // Frame done: receive buffer and flag
                    fend = 1'b1;
                    rxb_d = sh;
                    rir_d = 1'b1;
                    k_d = K_ZERO;
                    if (txf_q) begin
                        // Next word already waiting: no gap
                        load_ev = 1'b1;
                        sr_d = txb_q;
                        txf_d = 1'b0;
                        tir_d = 1'b1;
                        busy_d = 1'b1;
                        if (!ms || ph) begin
                            out_d = first_bit(txb_q, wm1, msb);
                            st_d = ms ? SSP_RUN : SSP_START;
                        end else begin
                            st_d = SSP_START;
                        end
                    end else begin
                        // Line keeps the last bit
                        busy_d = 1'b0;
                        st_d = SSP_IDLE;
                    end
                end else begin
                    k_d = 5'(k_q + K_ONE);
                    st_d = SSP_RUN;
                    busy_d = 1'b1;
                end
            end else if (ms && (st_q == SSP_START) && lead_tick) begin
                // Master begins on a generator tick
                out_d = first_bit(sr_q, wm1, msb);
                st_d = SSP_RUN;
                if (!ph) begin
                    clk_d = ~clk_q;
                    k_d = K_ONE;
                end
            end else if ((st_q == SSP_IDLE) && txf_q) begin
                // Empty shift register takes the buffer
                load_ev = 1'b1;
                sr_d = txb_q;
                txf_d = 1'b0;
                tir_d = 1'b1;
                busy_d = 1'b1;
                st_d = SSP_START;
                if (!ms) begin
                    ld_slave = 1'b1;
                    out_d = first_bit(txb_q, wm1, msb);
                end
            end
        end
        // Transmit buffer write after the engine took the old word
        if (wr_go && (wb_adr_i == ADR_TXB)) begin
            txb_d = merge(txb_q, wb_dat_i, wb_sel_i);
            txf_d = 1'b1;
        end
    end

    // Bus and engine registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RST;
            baud_q <= BAUD_RST;
            port_q <= PORT_RST;
            txb_q <= ZERO16;
            txf_q <= 1'b0;
            rxb_q <= ZERO16;
            busy_q <= 1'b0;
            tir_q <= 1'b0;
            rir_q <= 1'b0;
            sr_q <= ZERO16;
            out_q <= 1'b1;
            clk_q <= 1'b0;
            st_q <= SSP_IDLE;
            k_q <= K_ZERO;
            ack_q <= 1'b0;
            dat_q <= ZERO16;
        end else begin
            ctrl_q <= ctrl_d;
            baud_q <= baud_d;
            port_q <= port_d;
            txb_q <= txb_d;
            txf_q <= txf_d;
            rxb_q <= rxb_d;
            busy_q <= busy_d;
            tir_q <= tir_d;
            rir_q <= rir_d;
            sr_q <= sr_d;
            out_q <= out_d;
            clk_q <= clk_d;
            st_q <= st_d;
            k_q <= k_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_idle_clock;
        $rose(en) && ms |-> (clk_q == po) && (alt_sclk == po);
    endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("Clock not at idle level on enable");

    property p_hold_last;
        fend && !txf_q && en |=> (out_q == $past(out_q));
    endproperty
    a_hold_last: assert property (p_hold_last)
        else $error("Data line changed at frame end");

    property p_master_start;
        ms && en && (st_q == SSP_START) && lead_tick
            |=> (st_q == SSP_RUN) && (out_q == first_bit($past(sr_q), wm1, msb));
    endproperty
    a_master_start: assert property (p_master_start)
        else $error("Master did not present first bit on tick");

    property p_rx_copy;
        fend |=> rir_q && (rxb_q == $past(sh));
    endproperty
    a_rx_copy: assert property (p_rx_copy)
        else $error("Receive buffer or flag missing at frame end");

    property p_slave_first;
        ld_slave |=> (out_q == first_bit($past(txb_q), wm1, msb)) && (alt_min == out_q);
    endproperty
    a_slave_first: assert property (p_slave_first)
        else $error("Slave first bit not driven on load");

    property p_disabled_high;
        !en |-> alt_sclk && alt_mout && alt_min;
    endproperty
    a_disabled_high: assert property (p_disabled_high)
        else $error("Alternate output low while disabled");

    property p_baud_read;
        req && !wb_we_i && (wb_adr_i == ADR_BAUD) && en |=> (dat_q == $past(cnt_q));
    endproperty
    a_baud_read: assert property (p_baud_read)
        else $error("Baud read did not return the counter");

    property p_rate_min;
        (lead_tick && (baud_q == ZERO16)) ##1 en ##1 en |-> lead_tick;
    endproperty
    a_rate_min: assert property (p_rate_min)
        else $error("Tick spacing wrong for zero reload");

    property p_edge_on_tick;
        en && ms && $past(en) && (clk_q != $past(clk_q)) |-> $past(lead_tick || trail_tick);
    endproperty
    a_edge_on_tick: assert property (p_edge_on_tick)
        else $error("Master clock moved without a tick");

    property p_start_flags;
        load_ev |=> tir_q && busy_q;
    endproperty
    a_start_flags: assert property (p_start_flags)
        else $error("Busy or transmit flag not set at start");

endmodule // ssp_sync_serial_port

/* File: ssp_pkg.sv */
// Package: register map, field positions, reset values and states of the serial port
package ssp_pkg;
    // Register byte addresses on the Wishbone bus
    localparam logic [4:0] ADR_CTRL = 5'h00;
    localparam logic [4:0] ADR_BAUD = 5'h04;
    localparam logic [4:0] ADR_TXB = 5'h08;
    localparam logic [4:0] ADR_RXB = 5'h0C;
    localparam logic [4:0] ADR_STAT = 5'h10;
    localparam logic [4:0] ADR_PORT = 5'h14;
    // Control register fields
    localparam int CT_WID = 0;   // Word width minus one, four bits
    localparam int CT_MSB = 4;   // msb_first_sel
    localparam int CT_PH = 5;    // clock_phase_sel
    localparam int CT_PO = 6;    // clock_idle_level
    localparam int CT_MS = 7;    // master_select
    localparam int CT_EN = 15;   // port_enable
    // Status register fields
    localparam int ST_BSY = 0;   // busy_flag
    localparam int ST_TIR = 1;   // tx_irq_flag, write one clears
    localparam int ST_RIR = 2;   // rx_irq_flag, write one clears
    localparam int ST_TXF = 3;   // Transmit buffer holds data
    // Port register fields: latches 2:0, directions 5:3
    localparam int PT_SCLK = 0;
    localparam int PT_MOUT = 1;
    localparam int PT_MIN = 2;
    localparam int PT_DIR = 3;
    // Smallest legal width code (two bits)
    localparam logic [3:0] WID_MIN = 4'h1;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [5:0] PORT_RST = 6'h07;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [4:0] K_ZERO = 5'h00;
    localparam logic [4:0] K_ONE = 5'h01;
    // Transfer engine states, Gray coded along idle, start, run
    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_START = 2'b01,
        SSP_RUN = 2'b11
    } ssp_state_e;
endpackage

/* File: ssp_peer_model.sv */
// Peer model: the selected slave on the far side of the serial port
`timescale 1ns/1ns
module ssp_peer_model (
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    input wire logic idle,
    input wire logic pha,
    input wire logic msb,
    input wire logic [4:0] nbits,
    input wire logic [15:0] tx,
    input wire logic load,
    output logic [15:0] rx
);
    int k = 0; // Bits sampled so far in this frame

    // Bit position of the j-th bit on the line
    function automatic int idx(int j);
        return msb ? nbits - 1 - j : j;
    endfunction

    // Load presents the first bit at once
    always @(posedge load) begin
        k = 0;
        miso = tx[idx(0)];
    end

    // Sample on one edge, present the next bit on the other
    always @(sclk) begin
        if ((sclk !== idle) == pha) begin
            rx[idx(k)] = mosi;
            k = (k + 1) % nbits;
        end else begin
            miso = tx[idx(k)];
        end
    end
endmodule // ssp_peer_model

/* File: ssp_sync_serial_port_bench.sv */
// Testbench: register bus, master transfers against a peer, slave first bit
`timescale 1ns/1ns
module ssp_sync_serial_port_bench;
    import ssp_pkg::*;
    typedef struct {logic [15:0] v; logic [15:0] m;} ssp_note_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] wb_adr = 5'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h3;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack;
    logic sclk_o, sclk_oe_n, mout_o, mout_oe_n, min_o, min_oe_n;
    logic p_idle = 1'b0;
    logic p_pha = 1'b0;
    logic p_msb = 1'b0;
    logic [4:0] p_n = 5'h08;
    logic [15:0] p_tx = 16'h0;
    logic p_load = 1'b0;
    logic [15:0] p_rx;
    logic p_miso;
    logic [31:0] seed = 32'h152C;
    ssp_note_s exp_q[$];
    int bad_count = 0;
    int n_compared = 0;
    int leads, gmin, gmax, cyc_n, last_lead;
    logic sclk_prev = 1'b1;
    // Wire levels: clock and master out pulled high when nobody drives, master in from the peer
    wire sclk_w = (sclk_oe_n === 1'b0) ? sclk_o : 1'b1;
    wire mout_w = (mout_oe_n === 1'b0) ? mout_o : 1'b1;
    wire min_w = (min_oe_n === 1'b0) ? min_o : p_miso;

    ssp_sync_serial_port u_ssp_sync_serial_port (.clk(clk), .reset(reset), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .shift_clock_pin_i(sclk_w),
        .shift_clock_pin_o(sclk_o), .shift_clock_pin_oe_n(sclk_oe_n), .master_out_line_i(mout_w),
        .master_out_line_o(mout_o), .master_out_line_oe_n(mout_oe_n),
        .master_in_line_i(min_w), .master_in_line_o(min_o), .master_in_line_oe_n(min_oe_n));
    ssp_peer_model u_ssp_peer_model (.sclk(sclk_w), .mosi(mout_w), .miso(p_miso),
        .idle(p_idle), .pha(p_pha), .msb(p_msb), .nbits(p_n), .tx(p_tx), .load(p_load),
        .rx(p_rx));

    // Clock, 20 ns period
    initial begin
        forever #10 clk = ~clk;
    end

    // Xorshift source for data words
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    // Compare and count
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Counts, verdict, stop
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; reads note their expectation
    task automatic bus(logic [4:0] a, logic we, logic [15:0] d, logic [15:0] m,
                       output logic [15:0] q);
        int n;
        n = 0;
        if (!we) exp_q.push_back('{d, m});
        wb_adr <= a;
        wb_we <= we;
        wb_dat <= {16'h0000, d};
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 100);
        if (n >= 100) begin
            bad_count++;
            end_sim();
        end
        q = wb_dat_o[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(logic [4:0] a, logic [15:0] d);
        logic [15:0] q;
        bus(a, 1'b1, d, 16'h0000, q);
    endtask

    task automatic rd(logic [4:0] a, logic [15:0] e, logic [15:0] m);
        logic [15:0] q;
        bus(a, 1'b0, e, m, q);
    endtask

    // Settled pin levels {clock, master out, master in}
    task automatic pins(string name, logic [2:0] e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(name, {13'h0, sclk_o, mout_o, min_o}, {13'h0, e});
        @(posedge clk);
    endtask

    // Read checker: oldest note against returned data
    always @(posedge clk) begin
        ssp_note_s nt;
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
            nt = exp_q.pop_front();
            if (nt.m != 16'h0) check("read", wb_dat_o[15:0] & nt.m, nt.v & nt.m);
        end
    end

    // Leading clock edges and their spacing in cycles
    always @(posedge clk) begin
        cyc_n++;
        if (sclk_w !== sclk_prev && sclk_w !== p_idle) begin
            if (leads > 0 && cyc_n - last_lead < gmin) gmin = cyc_n - last_lead;
            if (leads > 0 && cyc_n - last_lead > gmax) gmax = cyc_n - last_lead;
            last_lead = cyc_n;
            leads++;
        end
        sclk_prev = sclk_w;
    end

    // Main sequence
    initial begin
        logic [15:0] q, d1, d2, cv, msk;
        int n, w;
        logic pm, ph, po, lb;
        lb = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(ADR_CTRL, CTRL_RST, 16'hFFFF);
        rd(ADR_PORT, {10'h000, PORT_RST}, 16'hFFFF);
        rd(5'h18, 16'h0000, 16'hFFFF);
        pins("reset", 3'b111);
        for (int i = 0; i < 4; i++) begin
            pm = i[0];
            ph = i[1];
            po = i[0] ^ i[1];
            w = i[0] ? 16 : 8;
            msk = i[0] ? 16'hFFFF : 16'h00FF;
            wr(ADR_BAUD, 16'h0003);
            rd(ADR_BAUD, 16'h0003, 16'hFFFF);
            // Idle level, latch, direction, enable, then alternate output
            cv = {8'h00, 1'b1, po, ph, pm, 4'(w - 1)};
            wr(ADR_CTRL, cv);
            wr(ADR_PORT, {10'h000, 3'b011, 2'b11, po});
            wr(ADR_CTRL, cv | 16'h8000);
            wr(ADR_PORT, 16'h001F);
            pins("enabled", {po, lb, 1'b1});
            p_idle = po;
            p_pha = ph;
            p_msb = pm;
            p_n = 5'(w);
            p_tx = rnd();
            d1 = rnd();
            d2 = rnd();
            p_load <= 1'b1;
            @(posedge clk);
            p_load <= 1'b0;
            leads = 0;
            gmin = 999;
            gmax = 0;
            wr(ADR_TXB, d1);
            wr(ADR_TXB, d2);
            n = 0;
            do begin
                bus(ADR_STAT, 1'b0, 16'h0, 16'h0, q);
                n++;
            end while (q[ST_BSY] !== 1'b0 && n < 200);
            if (n >= 200) begin
                bad_count++;
                end_sim();
            end
            check("leads", 16'(leads), 16'(2 * w));
            check("period_min", 16'(gmin), 16'h0008);
            check("period_max", 16'(gmax), 16'h0008);
            rd(ADR_STAT, 16'h0006, 16'h000F);
            rd(ADR_RXB, p_tx, msk);
            check("peer_rx", p_rx & msk, d2 & msk);
            // Line keeps the last bit sent until the next frame
            lb = pm ? d2[0] : d2[w - 1];
            pins("frame_end", {po, lb, 1'b1});
            wr(ADR_STAT, 16'h0006);
            rd(ADR_STAT, 16'h0000, 16'h0006);
            wr(ADR_CTRL, 16'h0000);
            pins("disabled", 3'b111);
            $display("test mode %0d done", i);
        end
        // Slave, idle high, MSB first: first bit out without any clock
        wr(ADR_BAUD, 16'h0001);
        wr(ADR_PORT, 16'h0027);
        wr(ADR_CTRL, 16'h8057);
        d1 = rnd() & 16'h007F;
        wr(ADR_TXB, d1);
        pins("slave_first", 3'b110);
        check("dirs", {13'h0, sclk_oe_n, mout_oe_n, min_oe_n}, 16'h0006);
        $display("test slave done");
        // Master at zero reload: fastest ticks, live counter read
        wr(ADR_CTRL, 16'h0000);
        wr(ADR_BAUD, 16'h0000);
        wr(ADR_CTRL, 16'h8087);
        rd(ADR_BAUD, 16'h0000, 16'hFFFF);
        $display("test zero reload done");
        end_sim();
    end
endmodule // ssp_sync_serial_port_bench
